// *** core/tpf_pkg.sv ***
// Package: register map, field layout and reset values of the pin function block
package tpf_pkg;
  localparam int TPF_ADDR_W = 12;
  localparam int TPF_DATA_W = 32;
  localparam int TPF_TIMER_W = 16;
  localparam int TPF_FIELD_W = 4;
  localparam int TPF_IOREG_W = 8;
  // Register byte addresses
  localparam logic [TPF_ADDR_W-1:0] TPF_OFF_CH4_IO_HIGH = 12'h000;
  localparam logic [TPF_ADDR_W-1:0] TPF_OFF_CH4_IO_LOW = 12'h004;
  localparam logic [TPF_ADDR_W-1:0] TPF_OFF_CH0_IO_HIGH = 12'h008;
  localparam logic [TPF_ADDR_W-1:0] TPF_OFF_CH4_MODE = 12'h00c;
  localparam logic [TPF_ADDR_W-1:0] TPF_OFF_CH4_GREG_B = 12'h010;
  localparam logic [TPF_ADDR_W-1:0] TPF_OFF_CH4_GREG_D = 12'h014;
  localparam logic [TPF_ADDR_W-1:0] TPF_OFF_CH0_GREG_A = 12'h018;
  localparam logic [TPF_ADDR_W-1:0] TPF_OFF_PIN_STATUS = 12'h01c;
  // Field positions: upper nibble of a high/low control register, lower nibble for ch0 A
  localparam int TPF_UPPER_LSB = 4;
  localparam int TPF_LOWER_LSB = 0;
  localparam int TPF_BUF_B_BIT = 4;
  // Field bit meanings
  localparam int TPF_FB_INPUT = 3;
  localparam int TPF_FB_LEVEL = 2;
  localparam int TPF_FB_BOTH = 1;
  localparam int TPF_FB_FALL = 0;
  // Compare actions held in the two low field bits
  localparam logic [1:0] TPF_ACT_KEEP = 2'h0;
  localparam logic [1:0] TPF_ACT_LOW = 2'h1;
  localparam logic [1:0] TPF_ACT_HIGH = 2'h2;
  localparam logic [1:0] TPF_ACT_TOGGLE = 2'h3;
  localparam logic [1:0] TPF_CASCADE_CODE = 2'h3;
  // Reset values
  localparam logic [TPF_IOREG_W-1:0] TPF_IOREG_RESET = 8'h00;
  localparam logic [TPF_TIMER_W-1:0] TPF_GREG_RESET = 16'hffff;
  localparam logic TPF_PIN_RESET = 1'h0;
  localparam logic [TPF_DATA_W-1:0] TPF_RDATA_ZERO = 32'h0000_0000;
endpackage

// *** core/tpf_pin_channel.sv ***
// One timer pin: output compare action or input capture event generation
`timescale 1ns/100ps
module tpf_pin_channel #(
  parameter int TIMER_W = tpf_pkg::TPF_TIMER_W,
  parameter bit CASCADE_EN = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [tpf_pkg::TPF_FIELD_W-1:0] field_in,
  input wire logic load_in,
  input wire logic [tpf_pkg::TPF_FIELD_W-1:0] load_field_in,
  input wire logic [TIMER_W-1:0] counter_in,
  input wire logic [TIMER_W-1:0] greg_in,
  input wire logic pin_in,
  input wire logic cascade_in,
  input wire logic inhibit_in,
  output logic pin_out,
  output logic pin_oe_out,
  output logic capture_out,
  output logic match_out,
  output logic [TIMER_W-1:0] cap_value_out
);
  import tpf_pkg::*;

  typedef struct packed {
    logic pin;
    logic oe;
    logic prev;
    logic capture;
    logic match;
    logic [TIMER_W-1:0] cap_value;
  } tpf_chan_type;

  tpf_chan_type st;
  tpf_chan_type next_st;
  logic rise;
  logic fall;
  logic cascade_sel;
  logic cap_ev;
  logic match_ev;

  // Event decode from the live field
  always_comb begin
    rise = pin_in & ~st.prev;
    fall = ~pin_in & st.prev;
    cascade_sel = CASCADE_EN && (field_in[TPF_FB_INPUT:TPF_FB_LEVEL] == TPF_CASCADE_CODE);
    cap_ev = 1'b0;
    if (!inhibit_in && field_in[TPF_FB_INPUT]) begin
      if (cascade_sel) begin
        cap_ev = cascade_in;
      end else if (field_in[TPF_FB_BOTH]) begin
        cap_ev = rise | fall;
      end else if (field_in[TPF_FB_FALL]) begin
        cap_ev = fall;
      end else begin
        cap_ev = rise;
      end
    end
    // Compare seen on the edge where counter equals register
    match_ev = !inhibit_in && !field_in[TPF_FB_INPUT] && (counter_in == greg_in);
  end

  // Next state: a register write sets the initial level, else the match action
  always_comb begin
    next_st = st;
    next_st.prev = pin_in;
    next_st.capture = cap_ev;
    next_st.match = match_ev;
    if (cap_ev) begin
      next_st.cap_value = counter_in;
    end
    if (inhibit_in) begin
      next_st.pin = st.pin;
    end else if (load_in) begin
      next_st.oe = ~load_field_in[TPF_FB_INPUT];
      if (!load_field_in[TPF_FB_INPUT] && load_field_in[1:0] != TPF_ACT_KEEP) begin
        next_st.pin = load_field_in[TPF_FB_LEVEL];
      end
    end else if (match_ev) begin
      case (field_in[1:0])
        TPF_ACT_LOW: begin
          next_st.pin = 1'b0;
        end
        TPF_ACT_HIGH: begin
          next_st.pin = 1'b1;
        end
        TPF_ACT_TOGGLE: begin
          next_st.pin = ~st.pin;
        end
        default: begin
          next_st.pin = st.pin;
        end
      endcase
    end
  end

  // Pin drives low with enable set out of reset until software reprograms it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.pin <= TPF_PIN_RESET;
      st.oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign pin_out = st.pin;
  assign pin_oe_out = st.oe;
  assign capture_out = st.capture;
  assign match_out = st.match;
  assign cap_value_out = st.cap_value;
endmodule

// *** core/tpf_top.sv ***
// Top: APB register file and three timer pin channels (ch4 B, ch4 D, ch0 A)
//
// Overview of operation
// - Codes 0000 and 0100 keep the pin; after reset pin drives low.
// - Codes 0001/0101 compare, pin low on match; initial level low/high.
// - Codes 0010/0110 compare, pin high on match; initial level follows bit 2.
// - Codes 0011/0111 compare, pin toggles on match; initial level low/high.
// - Top bit set, low bits 00: capture counter on rising edge.
// - Top bit set, low bits 01: capture counter on falling edge.
// - Top bit and bit 1 set: capture on both edges; ch0 needs bit 2 clear.
// - Ch0 A code 11xx captures whenever the channel 1 counter counts.
// - With pair B buffering on, D register acts as buffer and makes no events.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
module tpf_top #(
  parameter int TIMER_W = tpf_pkg::TPF_TIMER_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [tpf_pkg::TPF_ADDR_W-1:0] paddr_in,
  input wire logic [tpf_pkg::TPF_DATA_W-1:0] pwdata_in,
  output logic [tpf_pkg::TPF_DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [TIMER_W-1:0] ch4_counter_in,
  input wire logic [TIMER_W-1:0] ch0_counter_in,
  input wire logic ch1_count_in,
  input wire logic ch4_pin_b_in,
  output logic ch4_pin_b_out,
  output logic ch4_pin_b_oe_out,
  input wire logic ch4_pin_d_in,
  output logic ch4_pin_d_out,
  output logic ch4_pin_d_oe_out,
  input wire logic ch0_pin_a_in,
  output logic ch0_pin_a_out,
  output logic ch0_pin_a_oe_out
);
  import tpf_pkg::*;

  typedef struct packed {
    logic [TPF_IOREG_W-1:0] ch4_io_high;
    logic [TPF_IOREG_W-1:0] ch4_io_low;
    logic [TPF_IOREG_W-1:0] ch0_io_high;
    logic [TPF_IOREG_W-1:0] ch4_mode;
    logic [TIMER_W-1:0] greg_b;
    logic [TIMER_W-1:0] greg_d;
    logic [TIMER_W-1:0] greg_a;
    logic [TPF_DATA_W-1:0] rdata;
    logic ready;
    logic slverr;
  } tpf_top_type;

  tpf_top_type st;
  tpf_top_type next_st;
  logic setup_ph;
  logic wr_acc;
  logic hit;
  logic [TPF_DATA_W-1:0] rd_mux;
  logic wr_ch4_high;
  logic wr_ch4_low;
  logic wr_ch0_high;
  logic buf_b;
  logic [TPF_IOREG_W-1:0] wr_byte;
  logic cap_b;
  logic cap_d;
  logic cap_a;
  logic match_b;
  logic [TIMER_W-1:0] capv_b;
  logic [TIMER_W-1:0] capv_d;
  logic [TIMER_W-1:0] capv_a;

  // Address decode and read mux, sampled in the setup phase
  always_comb begin
    setup_ph = psel_in & ~penable_in;
    wr_acc = psel_in & penable_in & st.ready & pwrite_in;
    wr_byte = pwdata_in[TPF_IOREG_W-1:0];
    hit = 1'b1;
    rd_mux = TPF_RDATA_ZERO;
    case (paddr_in)
      TPF_OFF_CH4_IO_HIGH: begin
        rd_mux[TPF_IOREG_W-1:0] = st.ch4_io_high;
      end
      TPF_OFF_CH4_IO_LOW: begin
        rd_mux[TPF_IOREG_W-1:0] = st.ch4_io_low;
      end
      TPF_OFF_CH0_IO_HIGH: begin
        rd_mux[TPF_IOREG_W-1:0] = st.ch0_io_high;
      end
      TPF_OFF_CH4_MODE: begin
        rd_mux[TPF_IOREG_W-1:0] = st.ch4_mode;
      end
      TPF_OFF_CH4_GREG_B: begin
        rd_mux[TIMER_W-1:0] = st.greg_b;
      end
      TPF_OFF_CH4_GREG_D: begin
        rd_mux[TIMER_W-1:0] = st.greg_d;
      end
      TPF_OFF_CH0_GREG_A: begin
        rd_mux[TIMER_W-1:0] = st.greg_a;
      end
      TPF_OFF_PIN_STATUS: begin
        // Live pin levels and drive enables, read only
        rd_mux[5:0] = {ch0_pin_a_oe_out, ch0_pin_a_out, ch4_pin_d_oe_out,
                       ch4_pin_d_out, ch4_pin_b_oe_out, ch4_pin_b_out};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    wr_ch4_high = wr_acc && (paddr_in == TPF_OFF_CH4_IO_HIGH);
    wr_ch4_low = wr_acc && (paddr_in == TPF_OFF_CH4_IO_LOW);
    wr_ch0_high = wr_acc && (paddr_in == TPF_OFF_CH0_IO_HIGH);
    buf_b = st.ch4_mode[TPF_BUF_B_BIT];
  end

  // Register next values; hardware capture wins over a software write
  always_comb begin
    next_st = st;
    next_st.ready = setup_ph;
    if (setup_ph) begin
      next_st.rdata = pwrite_in ? TPF_RDATA_ZERO : rd_mux;
      next_st.slverr = ~hit;
    end else begin
      next_st.slverr = 1'b0;
    end
    if (wr_acc) begin
      case (paddr_in)
        TPF_OFF_CH4_IO_HIGH: begin
          next_st.ch4_io_high = wr_byte;
        end
        TPF_OFF_CH4_IO_LOW: begin
          next_st.ch4_io_low = wr_byte;
        end
        TPF_OFF_CH0_IO_HIGH: begin
          next_st.ch0_io_high = wr_byte;
        end
        TPF_OFF_CH4_MODE: begin
          next_st.ch4_mode = wr_byte;
        end
        TPF_OFF_CH4_GREG_B: begin
          next_st.greg_b = pwdata_in[TIMER_W-1:0];
        end
        TPF_OFF_CH4_GREG_D: begin
          next_st.greg_d = pwdata_in[TIMER_W-1:0];
        end
        TPF_OFF_CH0_GREG_A: begin
          next_st.greg_a = pwdata_in[TIMER_W-1:0];
        end
        default: begin
          next_st.ch4_mode = st.ch4_mode;
        end
      endcase
    end
    // Buffered pair: D feeds B on a B match, B's old value moves to D on capture
    if (buf_b && match_b) begin
      next_st.greg_b = st.greg_d;
    end
    if (cap_b) begin
      next_st.greg_b = capv_b;
      if (buf_b) begin
        next_st.greg_d = st.greg_b;
      end
    end
    if (cap_d) begin
      next_st.greg_d = capv_d;
    end
    if (cap_a) begin
      next_st.greg_a = capv_a;
    end
  end

  // Single clocked register for all register file state; each pin channel keeps its own
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.ch4_io_high <= TPF_IOREG_RESET;
      st.ch4_io_low <= TPF_IOREG_RESET;
      st.ch0_io_high <= TPF_IOREG_RESET;
      st.ch4_mode <= TPF_IOREG_RESET;
      st.greg_b <= TPF_GREG_RESET;
      st.greg_d <= TPF_GREG_RESET;
      st.greg_a <= TPF_GREG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Channel 4 B pin
  tpf_pin_channel #(
    .TIMER_W(TIMER_W),
    .CASCADE_EN(1'b0)
  ) u_ch4_b (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .field_in(st.ch4_io_high[TPF_UPPER_LSB +: TPF_FIELD_W]),
    .load_in(wr_ch4_high),
    .load_field_in(wr_byte[TPF_UPPER_LSB +: TPF_FIELD_W]),
    .counter_in(ch4_counter_in),
    .greg_in(st.greg_b),
    .pin_in(ch4_pin_b_in),
    .cascade_in(1'b0),
    .inhibit_in(1'b0),
    .pin_out(ch4_pin_b_out),
    .pin_oe_out(ch4_pin_b_oe_out),
    .capture_out(cap_b),
    .match_out(match_b),
    .cap_value_out(capv_b)
  );

  // Channel 4 D pin, silenced while it buffers B
  tpf_pin_channel #(
    .TIMER_W(TIMER_W),
    .CASCADE_EN(1'b0)
  ) u_ch4_d (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .field_in(st.ch4_io_low[TPF_UPPER_LSB +: TPF_FIELD_W]),
    .load_in(wr_ch4_low),
    .load_field_in(wr_byte[TPF_UPPER_LSB +: TPF_FIELD_W]),
    .counter_in(ch4_counter_in),
    .greg_in(st.greg_d),
    .pin_in(ch4_pin_d_in),
    .cascade_in(1'b0),
    .inhibit_in(buf_b),
    .pin_out(ch4_pin_d_out),
    .pin_oe_out(ch4_pin_d_oe_out),
    .capture_out(cap_d),
    .match_out(),
    .cap_value_out(capv_d)
  );

  // Channel 0 A pin with channel 1 count as cascade source
  tpf_pin_channel #(
    .TIMER_W(TIMER_W),
    .CASCADE_EN(1'b1)
  ) u_ch0_a (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .field_in(st.ch0_io_high[TPF_LOWER_LSB +: TPF_FIELD_W]),
    .load_in(wr_ch0_high),
    .load_field_in(wr_byte[TPF_LOWER_LSB +: TPF_FIELD_W]),
    .counter_in(ch0_counter_in),
    .greg_in(st.greg_a),
    .pin_in(ch0_pin_a_in),
    .cascade_in(ch1_count_in),
    .inhibit_in(1'b0),
    .pin_out(ch0_pin_a_out),
    .pin_oe_out(ch0_pin_a_oe_out),
    .capture_out(cap_a),
    .match_out(),
    .cap_value_out(capv_a)
  );

  assign prdata_out = st.rdata;
  assign pready_out = st.ready;
  assign pslverr_out = st.slverr;
endmodule

// *** tb/tpf_pin_model.sv ***
// Partner: outside drivers on the three timer pins
`timescale 1ns/100ps
module tpf_pin_model (
  input wire logic [2:0] ext_level_in,
  input wire logic [2:0] dev_level_in,
  input wire logic [2:0] dev_oe_in,
  output logic [2:0] wire_out
);
  // Outside driver backs off wherever the block drives, so no contention
  assign wire_out = (dev_oe_in & dev_level_in) | (~dev_oe_in & ext_level_in);
endmodule

// *** tb/tpf_top_sva.sv ***
// Checker: port-level assertions on the pin function block
`timescale 1ns/100ps
module tpf_top_sva #(
  parameter int TIMER_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [tpf_pkg::TPF_ADDR_W-1:0] paddr_in,
  input wire logic [tpf_pkg::TPF_DATA_W-1:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [TIMER_W-1:0] ch4_counter_in,
  input wire logic ch4_pin_b_out,
  input wire logic ch4_pin_b_oe_out,
  input wire logic ch4_pin_d_out
);
  import tpf_pkg::*;
  logic wr;
  logic mt;
  logic gv;
  logic bm;
  logic [3:0] fb;
  logic [TIMER_W-1:0] gb;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  assign wr = psel_in && penable_in && pwrite_in && pready_out;
  // Expected b match; captures or buffering spoil the shadow register
  assign mt = gv && !bm && !fb[3] && !wr && ch4_counter_in == gb;
  // Shadow of b field, b register and buffer mode as software set them
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fb <= 4'h0;
      gb <= '1;
      gv <= 1'b1;
      bm <= 1'b0;
    end else if (wr) begin
      if (paddr_in == TPF_OFF_CH4_IO_HIGH) fb <= pwdata_in[7:4];
      if (paddr_in == TPF_OFF_CH4_MODE) bm <= pwdata_in[TPF_BUF_B_BIT];
      if (paddr_in == TPF_OFF_CH4_GREG_B) gb <= pwdata_in[TIMER_W-1:0];
      gv <= (paddr_in == TPF_OFF_CH4_GREG_B) || gv && !(paddr_in == TPF_OFF_CH4_IO_HIGH
        && pwdata_in[7]) && !(paddr_in == TPF_OFF_CH4_MODE && pwdata_in[TPF_BUF_B_BIT]);
    end else if (fb[3]) begin
      // Captures may overwrite the register while in input mode
      gv <= 1'b0;
    end
  end
  AST_SETUP_READY:
    assert property (psel_in && !penable_in |=> pready_out) else $error("no ready");
  AST_READY_PULSE:
    assert property (pready_out |=> !pready_out) else $error("ready too long");
  AST_UNMAPPED:
    assert property (psel_in && !penable_in && paddr_in > TPF_OFF_PIN_STATUS
      |=> pslverr_out && pready_out) else $error("unmapped not refused");
  AST_RESET_LOW:
    assert property ($rose(rst_n_in) |-> !ch4_pin_b_out && ch4_pin_b_oe_out)
      else $error("pin b not low after reset");
  AST_KEEP_B:
    assert property (!fb[3] && fb[1:0] == TPF_ACT_KEEP && !wr |=> $stable(ch4_pin_b_out))
      else $error("pin b moved on keep");
  AST_LOW_B:
    assert property (mt && fb[1:0] == TPF_ACT_LOW |=> !ch4_pin_b_out) else $error("b not low");
  AST_HIGH_B:
    assert property (mt && fb[1:0] == TPF_ACT_HIGH |=> ch4_pin_b_out) else $error("b not high");
  AST_TOGGLE_B:
    assert property (mt && fb[1:0] == TPF_ACT_TOGGLE |=> ch4_pin_b_out != $past(ch4_pin_b_out))
      else $error("b not toggled");
  AST_INIT_B:
    assert property (wr && paddr_in == TPF_OFF_CH4_IO_HIGH && !pwdata_in[7]
      && pwdata_in[5:4] != 2'h0 |=> ch4_pin_b_out == $past(pwdata_in[6]) && ch4_pin_b_oe_out)
      else $error("b initial level wrong");
  AST_INPUT_OE:
    assert property (fb[3] |-> !ch4_pin_b_oe_out) else $error("b driven in capture mode");
  AST_BUF_D:
    assert property (bm |=> $stable(ch4_pin_d_out)) else $error("d moved in buffer mode");
endmodule
bind tpf_top tpf_top_sva #(.TIMER_W(TIMER_W)) tpf_top_sva_inst (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .ch4_counter_in(ch4_counter_in),
  .ch4_pin_b_out(ch4_pin_b_out), .ch4_pin_b_oe_out(ch4_pin_b_oe_out),
  .ch4_pin_d_out(ch4_pin_d_out));

// *** tb/timer_pin_function_select_test.sv ***
// Testbench: registers, compare, capture, cascade and buffer mode
`timescale 1ns/100ps
module timer_pin_function_select_test;
  import tpf_pkg::*;
  logic clk_in, rst_n_in, psel, pen, pwr, pready, pslverr, ch1_cnt, err, prev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cnt4, cnt0, c, base;
  logic [2:0] ext, pin_w, pin_o, pin_oe;
  int n_mismatch = 0;
  int total_checks = 0;
  int k;
  tpf_top tpf_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .ch4_counter_in(cnt4), .ch0_counter_in(cnt0),
    .ch1_count_in(ch1_cnt), .ch4_pin_b_in(pin_w[0]), .ch4_pin_b_out(pin_o[0]),
    .ch4_pin_b_oe_out(pin_oe[0]), .ch4_pin_d_in(pin_w[1]), .ch4_pin_d_out(pin_o[1]),
    .ch4_pin_d_oe_out(pin_oe[1]), .ch0_pin_a_in(pin_w[2]), .ch0_pin_a_out(pin_o[2]),
    .ch0_pin_a_oe_out(pin_oe[2]));
  tpf_pin_model tpf_pin_model_inst (.ext_level_in(ext), .dev_level_in(pin_o),
    .dev_oe_in(pin_oe), .wire_out(pin_w));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; an idle edge follows so drivers never reassign in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, {31'h0, pready});
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_in);
  endtask
  function automatic logic exp_pin(input logic [1:0] act, input logic old);
    return act == TPF_ACT_KEEP ? old : act == TPF_ACT_LOW ? 1'b0
      : act == TPF_ACT_HIGH ? 1'b1 : !old;
  endfunction
  function automatic logic cap_hit(input logic [3:0] code, input logic rising);
    return code[1] || (code[0] != rising);
  endfunction
  // Greg loaded after the mode change, since the switch itself may capture
  task automatic cap_run(input int p, input logic [3:0] code);
    logic [11:0] ga;
    ga = p ? TPF_OFF_CH0_GREG_A : TPF_OFF_CH4_GREG_B;
    apb(1'b1, p ? TPF_OFF_CH0_IO_HIGH : TPF_OFF_CH4_IO_HIGH,
      p ? {28'h0, code} : {24'h0, code, 4'h0});
    apb(1'b1, ga, 32'h0000_1234);
    base = 16'h1234;
    for (int e = 0; e < 2; e++) begin
      c = 16'($urandom);
      cnt4 <= c;
      cnt0 <= c;
      ext[2*p] <= (e == 0);
      repeat (3) @(posedge clk_in);
      apb(1'b0, ga, 32'h0);
      if (cap_hit(code, e == 0)) base = c;
      chk("capture value", {16'h0, base}, rd);
    end
  endtask
  initial begin
    rst_n_in = 1'b0;
    {psel, pen, pwr, ch1_cnt, ext} = 7'h0;
    {paddr, pwdata, cnt4, cnt0} = '0;
    void'($urandom(18755));
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    chk("pins after reset", 32'h38, {26'h0, pin_oe, pin_o});
    apb(1'b0, TPF_OFF_CH4_GREG_B, 32'h0);
    chk("greg b reset", 32'h0000_ffff, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    // Every output code on pin b, each with a random compare value
    prev = 1'b0;
    for (k = 0; k < 8; k++) begin
      apb(1'b1, TPF_OFF_CH4_IO_HIGH, 32'(k << 4));
      prev = (k[1:0] == 2'h0) ? prev : k[2];
      chk("b initial", {31'h0, prev}, {31'h0, pin_o[0]});
      c = 16'($urandom);
      apb(1'b1, TPF_OFF_CH4_GREG_B, {16'h0, c});
      cnt4 <= c;
      @(posedge clk_in);
      cnt4 <= c + 16'h1;
      @(posedge clk_in);
      prev = exp_pin(k[1:0], prev);
      chk("b after match", {31'h0, prev}, {31'h0, pin_o[0]});
    end
    for (k = 8; k < 16; k++) cap_run(0, k[3:0]);
    for (k = 8; k < 12; k++) cap_run(1, k[3:0]);
    // Cascade codes capture on a channel 1 count pulse
    for (k = 12; k < 16; k++) begin
      apb(1'b1, TPF_OFF_CH0_IO_HIGH, 32'(k));
      c = 16'($urandom);
      cnt0 <= c;
      ch1_cnt <= 1'b1;
      @(posedge clk_in);
      ch1_cnt <= 1'b0;
      repeat (2) @(posedge clk_in);
      apb(1'b0, TPF_OFF_CH0_GREG_A, 32'h0);
      chk("cascade capture", {16'h0, c}, rd);
    end
    // Buffer mode silences pin d even on a match
    apb(1'b1, TPF_OFF_CH4_MODE, 32'h10);
    apb(1'b1, TPF_OFF_CH4_IO_LOW, 32'h70);
    cnt4 <= 16'hffff;
    repeat (3) @(posedge clk_in);
    chk("d in buffer mode", 32'h0, {31'h0, pin_o[1]});
    cnt4 <= 16'h0;
    apb(1'b1, TPF_OFF_CH4_MODE, 32'h0);
    apb(1'b1, TPF_OFF_CH4_IO_LOW, 32'h70);
    chk("d after buffer off", 32'h1, {31'h0, pin_o[1]});
    // Ch0 A as toggling compare output; counter kept off the register until wanted
    c = 16'($urandom);
    cnt0 <= c + 16'h1;
    apb(1'b1, TPF_OFF_CH0_GREG_A, {16'h0, c});
    apb(1'b1, TPF_OFF_CH0_IO_HIGH, 32'h3);
    chk("a initial", 32'h2, {30'h0, pin_oe[2], pin_o[2]});
    cnt0 <= c;
    @(posedge clk_in);
    cnt0 <= c + 16'h1;
    @(posedge clk_in);
    chk("a after match", 32'h1, {31'h0, pin_o[2]});
    // Every pin level and drive enable, through the status word and live
    apb(1'b0, TPF_OFF_PIN_STATUS, 32'h0);
    chk("pin status", 32'h0000_003c, rd);
    chk("pin drive", 32'h36, {26'h0, pin_oe, pin_o});
    give_verdict();
  end
endmodule
